// *** logic/wkcs_pkg.sv ***
// package: register map, field positions and reset values for wake/checksum regs
package wkcs_pkg;
  localparam logic [7:0] wkcs_filter_window_offset = 8'ha8;
  localparam logic [7:0] wkcs_wake_ctrl_offset = 8'hac;
  localparam logic [7:0] wkcs_csum_ctrl_offset = 8'hb0;
  localparam logic [7:0] wkcs_irq_status_offset = 8'hb4;
  localparam logic [7:0] wkcs_irq_mask_offset = 8'hb8;
  localparam logic [7:0] wkcs_vlan_tag_offset = 8'ha0;
  localparam int wkcs_gue_bit = 9;
  localparam int wkcs_frame_flag_bit = 6;
  localparam int wkcs_pattern_flag_bit = 5;
  localparam int wkcs_frame_en_bit = 2;
  localparam int wkcs_pattern_en_bit = 1;
  localparam int wkcs_tx_csum_en_bit = 16;
  localparam int wkcs_rx_mode_bit = 1;
  localparam int wkcs_rx_csum_en_bit = 0;
  localparam int wkcs_filter_entries = 8;
  localparam logic [31:0] wkcs_filter_reset = 32'h0000_0000;
  localparam logic [15:0] wkcs_vlan_tag_reset = 16'hffff;
  localparam logic [7:0] wkcs_plain_start_bytes = 8'h0e;
  localparam int wkcs_irq_bits = 3;
  typedef enum logic [2:0] {
    wkcs_idle = 3'b001,
    wkcs_setup = 3'b010,
    wkcs_access = 3'b100
  } wkcs_apb_state_type;
endpackage : wkcs_pkg

// *** logic/wkcs_filter_store.sv ***
// eight-entry wakeup filter storage with auto-advancing shared pointer
module wkcs_filter_store #(
  parameter int entries = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_step,
  input wire logic rd_step,
  input wire logic [31:0] wr_data,
  input wire logic [$clog2(entries)-1:0] match_index,
  output logic [31:0] rd_data,
  output logic [31:0] match_word,
  output logic [$clog2(entries)-1:0] pointer
);
  localparam int pw = $clog2(entries);
  logic [31:0] store [entries];
  logic [pw-1:0] next_pointer;

  ////////////////////////////////////////////////////////////////////////
  // wraps after the last entry so the next set starts at entry zero
  assign next_pointer = (pointer == pw'(entries - 1)) ? '0 : pointer + 1'b1;
  assign rd_data = store[pointer];
  assign match_word = store[match_index];

  // pointer moves on every complete read or write of the window
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pointer <= '0;
    end else if (wr_step || rd_step) begin
      pointer <= next_pointer;
    end
  end

  // entries reset to zero, a write lands at the current pointer
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < entries; i++) begin
      if (rst) begin
        store[i] <= wkcs_pkg::wkcs_filter_reset;
      end else if (wr_step && pointer == pw'(i)) begin
        store[i] <= wr_data;
      end
    end
  end
endmodule : wkcs_filter_store

// *** logic/wkcs_regs.sv ***
// wakeup filter, wake control/status and checksum offload control registers
//
// Register access over APB was left to the implementer.
module wkcs_regs (
  input wire logic core_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive side events and frame info, same clock domain
  input wire logic rx_frame_done,
  input wire logic rx_dest_addr_bit0,
  input wire logic rx_filter_hit,
  input wire logic rx_pattern_hit,
  input wire logic [15:0] first_vlan_tag_id,
  // filter lookup port for the matcher
  input wire logic [2:0] filter_match_index,
  output logic [31:0] wakeup_filter_contents,
  // controls towards the datapaths
  output logic tx_checksum_engine_enable,
  output logic rx_checksum_engine_enable,
  output logic rx_checksum_start_select,
  output logic [7:0] rx_checksum_plain_start,
  output logic [15:0] rx_checksum_vlan_id,
  output logic wake_frame_filter_active,
  output logic pattern_wake_active,
  output logic unicast_wake,
  output logic wake_indication,
  output logic irq
);
  localparam int n = wkcs_pkg::wkcs_filter_entries;

  ////////////////////////////////////////////////////////////////////////
  // apb: one wait state, access answered the cycle after it starts
  wkcs_pkg::wkcs_apb_state_type state;
  wkcs_pkg::wkcs_apb_state_type next_state;
  logic done;
  logic wr_fire;
  logic rd_fire;

  always_comb begin
    next_state = state;
    case (state)
      wkcs_pkg::wkcs_idle: begin
        if (psel && !penable) begin
          next_state = wkcs_pkg::wkcs_setup;
        end
      end
      wkcs_pkg::wkcs_setup: begin
        if (psel && penable) begin
          next_state = wkcs_pkg::wkcs_access;
        end
      end
      wkcs_pkg::wkcs_access: begin
        next_state = wkcs_pkg::wkcs_idle;
      end
      default: begin
        next_state = wkcs_pkg::wkcs_idle;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= wkcs_pkg::wkcs_idle;
    end else begin
      state <= next_state;
    end
  end

  assign done = (state == wkcs_pkg::wkcs_access) && psel && penable;
  assign pready = (state == wkcs_pkg::wkcs_access);
  assign wr_fire = done && pwrite;
  assign rd_fire = done && !pwrite;

  ////////////////////////////////////////////////////////////////////////
  // address decode
  logic sel_filter;
  logic sel_wake;
  logic sel_csum;
  logic sel_stat;
  logic sel_mask;
  logic mapped;
  assign sel_filter = paddr == wkcs_pkg::wkcs_filter_window_offset;
  assign sel_wake = paddr == wkcs_pkg::wkcs_wake_ctrl_offset;
  assign sel_csum = paddr == wkcs_pkg::wkcs_csum_ctrl_offset;
  assign sel_stat = paddr == wkcs_pkg::wkcs_irq_status_offset;
  assign sel_mask = paddr == wkcs_pkg::wkcs_irq_mask_offset;
  assign mapped = sel_filter | sel_wake | sel_csum | sel_stat | sel_mask;
  assign pslverr = pready && !mapped; // unmapped address answers with error

  ////////////////////////////////////////////////////////////////////////
  // filter window: pointer steps only on the access-completing edge
  logic [31:0] filter_rd;
  wkcs_filter_store #(
    .entries(n)
  ) u_filter (
    .core_clk(core_clk),
    .rst(rst),
    .wr_step(wr_fire && sel_filter),
    .rd_step(rd_fire && sel_filter),
    .wr_data(pwdata),
    .match_index(filter_match_index),
    .rd_data(filter_rd),
    .match_word(wakeup_filter_contents),
    .pointer()
  );
  // a partial sequence leaves the pointer off zero; software must finish sets

  ////////////////////////////////////////////////////////////////////////
  // wake control/status
  logic global_unicast_wake_enable;
  logic wake_frame_enable;
  logic pattern_packet_wake_enable;
  logic wakeup_frame_received_flag;
  logic pattern_packet_received_flag;
  logic frame_event;
  logic pattern_event;
  logic unicast_event;
  logic clr_frame;
  logic clr_pattern;

  assign frame_event = rx_frame_done && rx_filter_hit && wake_frame_enable;
  assign pattern_event = rx_frame_done && rx_pattern_hit
    && pattern_packet_wake_enable;
  assign unicast_event = rx_frame_done && !rx_dest_addr_bit0
    && global_unicast_wake_enable;
  assign clr_frame = wr_fire && sel_wake && pwdata[wkcs_pkg::wkcs_frame_flag_bit];
  assign clr_pattern = wr_fire && sel_wake
    && pwdata[wkcs_pkg::wkcs_pattern_flag_bit];

  // enables written directly; flags set wins over write-one clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      global_unicast_wake_enable <= 1'b0;
      wake_frame_enable <= 1'b0;
      pattern_packet_wake_enable <= 1'b0;
      wakeup_frame_received_flag <= 1'b0;
      pattern_packet_received_flag <= 1'b0;
    end else begin
      if (wr_fire && sel_wake) begin
        global_unicast_wake_enable <= pwdata[wkcs_pkg::wkcs_gue_bit];
        wake_frame_enable <= pwdata[wkcs_pkg::wkcs_frame_en_bit];
        pattern_packet_wake_enable <= pwdata[wkcs_pkg::wkcs_pattern_en_bit];
      end
      if (frame_event) begin
        wakeup_frame_received_flag <= 1'b1;
      end else if (clr_frame) begin
        wakeup_frame_received_flag <= 1'b0;
      end
      if (pattern_event) begin
        pattern_packet_received_flag <= 1'b1;
      end else if (clr_pattern) begin
        pattern_packet_received_flag <= 1'b0;
      end
    end
  end

  // one-cycle wake pulse on a global unicast frame
  always_ff @(posedge core_clk) begin
    if (rst) begin
      unicast_wake <= 1'b0;
    end else begin
      unicast_wake <= unicast_event;
    end
  end

  assign wake_frame_filter_active = wake_frame_enable;
  assign pattern_wake_active = pattern_packet_wake_enable;
  assign wake_indication = wakeup_frame_received_flag
    | pattern_packet_received_flag;

  ////////////////////////////////////////////////////////////////////////
  // checksum offload control; changing it live is the software's hazard
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_checksum_engine_enable <= 1'b0;
      rx_checksum_start_select <= 1'b0;
      rx_checksum_engine_enable <= 1'b0;
    end else if (wr_fire && sel_csum) begin
      tx_checksum_engine_enable <= pwdata[wkcs_pkg::wkcs_tx_csum_en_bit];
      rx_checksum_start_select <= pwdata[wkcs_pkg::wkcs_rx_mode_bit];
      rx_checksum_engine_enable <= pwdata[wkcs_pkg::wkcs_rx_csum_en_bit];
    end
  end

  // fixed start offset for mode zero; vlan id steered from tag register
  assign rx_checksum_plain_start = wkcs_pkg::wkcs_plain_start_bytes;
  // registered copy of the tag register, same domain
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_checksum_vlan_id <= wkcs_pkg::wkcs_vlan_tag_reset;
    end else begin
      rx_checksum_vlan_id <= first_vlan_tag_id;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts: bit0 frame flag, bit1 pattern flag, bit2 unicast wake
  logic [wkcs_pkg::wkcs_irq_bits-1:0] irq_status;
  logic [wkcs_pkg::wkcs_irq_bits-1:0] irq_mask;
  logic [wkcs_pkg::wkcs_irq_bits-1:0] irq_set;
  logic [wkcs_pkg::wkcs_irq_bits-1:0] irq_clr;
  assign irq_set = {unicast_event, pattern_event, frame_event};
  assign irq_clr = (wr_fire && sel_stat)
    ? pwdata[wkcs_pkg::wkcs_irq_bits-1:0] : '0;

  // sticky status, set beats clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      if (wr_fire && sel_mask) begin
        irq_mask <= pwdata[wkcs_pkg::wkcs_irq_bits-1:0];
      end
    end
  end
  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // read mux, registered so data comes from flip-flops
  logic [31:0] wake_word;
  logic [31:0] csum_word;
  logic [31:0] rd_word;
  always_comb begin
    wake_word = 32'h0000_0000;
    wake_word[wkcs_pkg::wkcs_gue_bit] = global_unicast_wake_enable;
    wake_word[wkcs_pkg::wkcs_frame_flag_bit] = wakeup_frame_received_flag;
    wake_word[wkcs_pkg::wkcs_pattern_flag_bit] = pattern_packet_received_flag;
    wake_word[wkcs_pkg::wkcs_frame_en_bit] = wake_frame_enable;
    wake_word[wkcs_pkg::wkcs_pattern_en_bit] = pattern_packet_wake_enable;
    csum_word = 32'h0000_0000;
    csum_word[wkcs_pkg::wkcs_tx_csum_en_bit] = tx_checksum_engine_enable;
    csum_word[wkcs_pkg::wkcs_rx_mode_bit] = rx_checksum_start_select;
    csum_word[wkcs_pkg::wkcs_rx_csum_en_bit] = rx_checksum_engine_enable;
  end
  assign rd_word = sel_filter ? filter_rd
    : sel_wake ? wake_word
    : sel_csum ? csum_word
    : sel_stat ? {29'h0000_0000, irq_status}
    : sel_mask ? {29'h0000_0000, irq_mask}
    : 32'h0000_0000;

  // captured in the setup-to-access step, held through the answer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (next_state == wkcs_pkg::wkcs_access && !pwrite) begin
      prdata <= rd_word;
    end
  end
endmodule : wkcs_regs

// *** tb/wkcs_regs_sva.sv ***
// checker: port-level properties of the wake and checksum register block
module wkcs_regs_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_frame_done,
  input wire logic rx_dest_addr_bit0,
  input wire logic rx_filter_hit,
  input wire logic rx_pattern_hit,
  input wire logic [15:0] first_vlan_tag_id,
  input wire logic tx_checksum_engine_enable,
  input wire logic rx_checksum_engine_enable,
  input wire logic rx_checksum_start_select,
  input wire logic [7:0] rx_checksum_plain_start,
  input wire logic [15:0] rx_checksum_vlan_id,
  input wire logic wake_frame_filter_active,
  input wire logic pattern_wake_active,
  input wire logic unicast_wake,
  input wire logic wake_indication
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // completed writes per register; the only legal cause of a control change
  wire done_w = psel && penable && pready && pwrite;
  wire wake_wr = done_w && paddr == 8'hac;
  wire csum_wr = done_w && paddr == 8'hb0;
  wire mapped = paddr inside {8'ha8, 8'hac, 8'hb0, 8'hb4, 8'hb8};
  sequence setup_s;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence answer_s;
    !pready ##1 pready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  apb_wait_a: assert property (setup_s |-> answer_s) else $error("no wait");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready");
  map_ok_a: assert property (pready && mapped |-> !pslverr) else $error("err");
  unicast_cause_a: assert property (unicast_wake |->
    $past(rx_frame_done && !rx_dest_addr_bit0)) else $error("unicast");
  frame_flag_a: assert property (rx_frame_done &&
    rx_filter_hit && wake_frame_filter_active |=> wake_indication)
    else $error("frame");
  pattern_flag_a: assert property (rx_frame_done &&
    rx_pattern_hit && pattern_wake_active |=> wake_indication)
    else $error("pattern");
  flag_clear_a: assert property ($fell(wake_indication) |->
    $past(wake_wr)) else $error("flag clear");
  csum_hold_a: assert property ($changed({
    tx_checksum_engine_enable, rx_checksum_engine_enable,
    rx_checksum_start_select}) |-> $past(csum_wr)) else $error("csum ctrl");
  plain_start_a: assert property (rx_checksum_plain_start == 8'h0e)
    else $error("start");
  vlan_follow_a: assert property (!$past(rst) |->
    rx_checksum_vlan_id == $past(first_vlan_tag_id)) else $error("vlan");
endmodule : wkcs_regs_sva
bind wkcs_regs wkcs_regs_sva i_wkcs_regs_sva (.*);

// *** tb/wakeup_and_checksum_ctrl_regs_test.sv ***
// testbench: apb register tests of the wake and checksum register block
module wakeup_and_checksum_ctrl_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, err, irq, unicast_wake;
  logic [7:0] paddr = 8'h00, rx_checksum_plain_start;
  logic [31:0] pwdata = 32'h0, prdata, rd, wakeup_filter_contents;
  logic rx_frame_done = 1'h0, rx_dest_addr_bit0 = 1'h1;
  logic rx_filter_hit = 1'h0, rx_pattern_hit = 1'h0;
  logic [15:0] first_vlan_tag_id = 16'h8100, rx_checksum_vlan_id;
  logic [2:0] filter_match_index = 3'h0;
  logic tx_checksum_engine_enable, rx_checksum_engine_enable;
  logic rx_checksum_start_select, wake_frame_filter_active;
  logic pattern_wake_active, wake_indication;
  int bad_count = 0, compares = 0, cycles = 0;
  wkcs_regs i_wkcs_regs (.*);
  ////////////////////////////////////////////////////////////////////////////
  // clock and a hang limit well above the few hundred cycles used
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      stop_test();
    end
  end
  task stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    // no cycle count assumed; only the hang limit ends this wait
    while (pready !== 1'h1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'h0, a, 32'h0);
    chk(rd, exp, nm);
  endtask : rdchk
  // one received-frame pulse; returns when flags and the wake pulse show
  task ev(input logic fh, input logic ph, input logic b0);
    @(posedge core_clk);
    rx_frame_done <= 1'h1;
    rx_filter_hit <= fh;
    rx_pattern_hit <= ph;
    rx_dest_addr_bit0 <= b0;
    @(posedge core_clk);
    rx_frame_done <= 1'h0;
    @(posedge core_clk);
  endtask : ev
  task look(input int i, input logic [31:0] exp);
    filter_match_index <= 3'(i);
    @(posedge core_clk);
    chk(wakeup_filter_contents, exp, "entry");
  endtask : look
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    look(7, 32'h0);
    rdchk(8'hac, 32'h0, "wake ctl");
    rdchk(8'hb0, 32'h0, "csum ctl");
    // whole sets only, so each pass leaves the shared pointer at entry zero
    for (int i = 0; i < 8; i++) begin
      apb(1'h1, 8'ha8, 32'ha5a5_0000 + 32'(i));
    end
    for (int i = 0; i < 8; i++) begin
      rdchk(8'ha8, 32'ha5a5_0000 + 32'(i), "win");
    end
    for (int i = 0; i < 8; i++) begin
      look(i, 32'ha5a5_0000 + 32'(i));
    end
    // after sixteen accesses the pointer must be back at entry zero
    for (int i = 0; i < 8; i++) begin
      apb(1'h1, 8'ha8, 32'h5a5a_0000 + 32'(i));
    end
    look(0, 32'h5a5a_0000);
    look(7, 32'h5a5a_0007);
    ev(1'h1, 1'h1, 1'h0);
    chk(wake_indication, 1'h0, "off");
    chk(unicast_wake, 1'h0, "uni off");
    apb(1'h1, 8'hac, 32'hffff_ff9f);
    rdchk(8'hac, 32'h0000_0206, "wake ctl");
    chk(wake_frame_filter_active, 1'h1, "wf");
    chk(pattern_wake_active, 1'h1, "pw");
    apb(1'h1, 8'hb8, 32'h7);
    ev(1'h1, 1'h0, 1'h1);
    chk(wake_indication, 1'h1, "wake");
    chk(unicast_wake, 1'h0, "uni b0");
    chk(irq, 1'h1, "irq");
    rdchk(8'hac, 32'h0000_0246, "wake ctl");
    ev(1'h0, 1'h1, 1'h0);
    chk(unicast_wake, 1'h1, "uni");
    rdchk(8'hac, 32'h0000_0266, "wake ctl");
    apb(1'h1, 8'hac, 32'h0000_0246);
    rdchk(8'hac, 32'h0000_0226, "w1c");
    apb(1'h1, 8'hac, 32'h0000_0226);
    // the clear lands at the edge the write ends on; look one edge later
    @(posedge core_clk);
    chk(wake_indication, 1'h0, "wake");
    rdchk(8'hb4, 32'h7, "status");
    apb(1'h1, 8'hb8, 32'h0);
    @(posedge core_clk);
    chk(irq, 1'h0, "masked");
    apb(1'h1, 8'hb4, 32'h7);
    apb(1'h1, 8'hb8, 32'h7);
    rdchk(8'hb4, 32'h0, "status");
    chk(irq, 1'h0, "irq clr");
    // no frames are moving, so a change is safe
    apb(1'h1, 8'hb0, 32'hffff_ffff);
    rdchk(8'hb0, 32'h0001_0003, "csum ctl");
    chk({tx_checksum_engine_enable, rx_checksum_engine_enable,
      rx_checksum_start_select}, 3'h7, "csum out");
    chk(rx_checksum_plain_start, 8'h0e, "start");
    apb(1'h1, 8'hc0, 32'hffff_ffff);
    chk(err, 1'h1, "slverr");
    rdchk(8'hc0, 32'h0, "unmapped");
    chk(err, 1'h1, "slverr");
    first_vlan_tag_id <= 16'h88a8;
    repeat (2) @(posedge core_clk);
    chk(rx_checksum_vlan_id, 16'h88a8, "vlan");
    rst <= 1'h1;
    repeat (2) @(posedge core_clk);
    chk(rx_checksum_vlan_id, 16'hffff, "vlan rst");
    rst <= 1'h0;
    rdchk(8'hb0, 32'h0, "csum rst");
    stop_test();
  end
endmodule : wakeup_and_checksum_ctrl_regs_test
